/* File: hdl/cbss_regs.sv */
// card-side error status, bus number registers and forward decision
// also holds the flag and bus number cells that the top module instantiates
// assumes a config access port clocked by SYS_CLK; RST_N is the global reset
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// one write-1-to-clear error flag
// ****************************************
// set wins over a same-cycle clear so no event is lost
module cbss_sticky_bit #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic set_evt,
  input wire logic clr_req,
  output logic flag_r
);

  logic flag_nxt;

  always_comb begin
    flag_nxt = flag_r;
    if (clr_req) begin
      flag_nxt = 1'b0;
    end
    if (set_evt) begin
      flag_nxt = 1'b1;
    end
  end

  // only the global reset reaches this flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= RST_VAL;
    end else begin
      flag_r <= flag_nxt;
    end
  end

endmodule

// ****************************************
// one host-programmed bus number byte
// ****************************************
module cbss_byte_reg #(
  parameter logic [7:0] RST_VAL = 8'h00
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sync_rst_n,
  input wire logic wr_en,
  input wire logic [7:0] wr_byte,
  output logic [7:0] val_r
);

  logic [7:0] val_nxt;

  // bus reset is synchronous; a write in the same cycle is dropped
  always_comb begin
    val_nxt = val_r;
    if (!sync_rst_n) begin
      val_nxt = RST_VAL;
    end else if (wr_en) begin
      val_nxt = wr_byte;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      val_r <= RST_VAL;
    end else begin
      val_r <= val_nxt;
    end
  end

endmodule

module cbss_regs (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic BUS_RST_N,
  input wire cbss_pkg::cbss_cfg_req_t CFG_REQ,
  output logic [31:0] CFG_RDATA,
  output logic CFG_RVALID,
  input wire cbss_pkg::cbss_event_t CARD_EVT,
  input wire logic PARITY_RESP_EN,
  output logic CARD_SERR_OE,
  input wire logic FWD_REQ,
  input wire logic FWD_IS_TYPE1,
  input wire logic [7:0] FWD_BUS,
  output logic FWD_VALID,
  output cbss_pkg::cbss_fwd_t FWD_ACTION
);

  // ****************************************
  // decode
  // ****************************************
  // address decode
  logic hit_status;
  logic hit_bus;

  // status flag events and clears, one bit per flag
  logic [5:0] clr_bits;
  logic [5:0] set_bits;
  logic parity_r;
  logic serr_r;
  logic mabort_r;
  logic ta_rcvd_r;
  logic ta_sig_r;
  logic dpar_r;
  logic [15:0] status;

  // bus number registers and their byte-lane write strobes
  logic [7:0] up_bus_r;
  logic [7:0] card_bus_r;
  logic [7:0] sub_bus_r;
  logic up_wr;
  logic card_wr;
  logic sub_wr;

  // next values of the registered outputs
  logic [31:0] rdata_nxt;
  cbss_pkg::cbss_fwd_t fwd_action_nxt;

  assign hit_status = (CFG_REQ.dw_addr == cbss_pkg::CBSS_OFS_STATUS[7:2]);
  assign hit_bus = (CFG_REQ.dw_addr == cbss_pkg::CBSS_OFS_UP_BUS[7:2]);

  // ****************************************
  // card error line
  // ****************************************
  // the bridge only observes the card's error line, never drives it
  assign CARD_SERR_OE = 1'b0;

  // ****************************************
  // sticky error bits {15,14,13,12,11,8}
  // ****************************************
  always_comb begin
    set_bits[5] = CARD_EVT.addr_parity_err | CARD_EVT.data_parity_err;
    set_bits[4] = CARD_EVT.serr_seen;
    set_bits[3] = CARD_EVT.master_abort;
    set_bits[2] = CARD_EVT.target_abort_rcvd;
    set_bits[1] = CARD_EVT.target_abort_sig;
    set_bits[0] = CARD_EVT.perr_seen & CARD_EVT.is_master & PARITY_RESP_EN;
  end

  // ****************************************
  // status clear decode
  // ****************************************
  always_comb begin
    clr_bits = 6'h00;
    if (CFG_REQ.wr && hit_status) begin
      if (CFG_REQ.be[3]) begin
        clr_bits[5:1] = CFG_REQ.wdata[31:27];
      end
      // bit 8 shares the upper byte lane with bits 15 to 11
      if (CFG_REQ.be[3]) begin
        clr_bits[0] = CFG_REQ.wdata[24];
      end
    end
  end

  // ****************************************
  // sticky flag cells
  // ****************************************
  // only the global reset reaches these; bus reset deliberately ignored
  // bit 15: card-side parity error, address or data phase
  cbss_sticky_bit #(
    .RST_VAL(cbss_pkg::CBSS_STATUS_RST[cbss_pkg::CBSS_B_PARITY])
  ) u_parity_flag (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .set_evt(set_bits[5]),
    .clr_req(clr_bits[5]),
    .flag_r(parity_r)
  );

  // bit 14: system error driven by the card
  cbss_sticky_bit #(
    .RST_VAL(cbss_pkg::CBSS_STATUS_RST[cbss_pkg::CBSS_B_SERR])
  ) u_serr_flag (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .set_evt(set_bits[4]),
    .clr_req(clr_bits[4]),
    .flag_r(serr_r)
  );

  // bit 13: master abort on a cycle we started
  cbss_sticky_bit #(
    .RST_VAL(cbss_pkg::CBSS_STATUS_RST[cbss_pkg::CBSS_B_MABORT])
  ) u_mabort_flag (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .set_evt(set_bits[3]),
    .clr_req(clr_bits[3]),
    .flag_r(mabort_r)
  );

  // bit 12: target abort received on a cycle we started
  cbss_sticky_bit #(
    .RST_VAL(cbss_pkg::CBSS_STATUS_RST[cbss_pkg::CBSS_B_TA_RCVD])
  ) u_ta_rcvd_flag (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .set_evt(set_bits[2]),
    .clr_req(clr_bits[2]),
    .flag_r(ta_rcvd_r)
  );

  // bit 11: target abort signaled by us as target
  cbss_sticky_bit #(
    .RST_VAL(cbss_pkg::CBSS_STATUS_RST[cbss_pkg::CBSS_B_TA_SIG])
  ) u_ta_sig_flag (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .set_evt(set_bits[1]),
    .clr_req(clr_bits[1]),
    .flag_r(ta_sig_r)
  );

  // bit 8: data parity error reported while we were master
  cbss_sticky_bit #(
    .RST_VAL(cbss_pkg::CBSS_STATUS_RST[cbss_pkg::CBSS_B_DPAR])
  ) u_dpar_flag (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .set_evt(set_bits[0]),
    .clr_req(clr_bits[0]),
    .flag_r(dpar_r)
  );

  // ****************************************
  // status image
  // ****************************************
  always_comb begin
    status = 16'h0000;
    status[cbss_pkg::CBSS_B_PARITY] = parity_r;
    status[cbss_pkg::CBSS_B_SERR] = serr_r;
    status[cbss_pkg::CBSS_B_MABORT] = mabort_r;
    status[cbss_pkg::CBSS_B_TA_RCVD] = ta_rcvd_r;
    status[cbss_pkg::CBSS_B_TA_SIG] = ta_sig_r;
    status[cbss_pkg::CBSS_B_SPEED_LO +: 2] = cbss_pkg::CBSS_SPEED_MEDIUM;
    status[cbss_pkg::CBSS_B_DPAR] = dpar_r;
  end

  // ****************************************
  // bus number registers
  // ****************************************
  // a write only lands on the byte lanes that are enabled
  assign up_wr = CFG_REQ.wr && hit_bus && CFG_REQ.be[0];
  assign card_wr = CFG_REQ.wr && hit_bus && CFG_REQ.be[1];
  assign sub_wr = CFG_REQ.wr && hit_bus && CFG_REQ.be[2];

  // upstream bus number, byte 0 of the dword
  cbss_byte_reg #(
    .RST_VAL(cbss_pkg::CBSS_BUS_RST)
  ) u_up_bus (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .sync_rst_n(BUS_RST_N),
    .wr_en(up_wr),
    .wr_byte(CFG_REQ.wdata[7:0]),
    .val_r(up_bus_r)
  );

  // card-side bus number, byte 1 of the dword
  cbss_byte_reg #(
    .RST_VAL(cbss_pkg::CBSS_BUS_RST)
  ) u_card_bus (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .sync_rst_n(BUS_RST_N),
    .wr_en(card_wr),
    .wr_byte(CFG_REQ.wdata[15:8]),
    .val_r(card_bus_r)
  );

  // subordinate bus number, byte 2 of the dword
  cbss_byte_reg #(
    .RST_VAL(cbss_pkg::CBSS_BUS_RST)
  ) u_sub_bus (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .sync_rst_n(BUS_RST_N),
    .wr_en(sub_wr),
    .wr_byte(CFG_REQ.wdata[23:16]),
    .val_r(sub_bus_r)
  );

  // ****************************************
  // read path
  // ****************************************
  always_comb begin
    rdata_nxt = CFG_RDATA;
    if (CFG_REQ.rd) begin
      if (hit_status) begin
        rdata_nxt = {status, 16'h0000};
      end else if (hit_bus) begin
        rdata_nxt = {8'h00, sub_bus_r, card_bus_r, up_bus_r};
      end else begin
        rdata_nxt = 32'h0000_0000;
      end
    end
  end

  // read data holds until the next read so a slow host can take it late
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      CFG_RDATA <= 32'h0000_0000;
      CFG_RVALID <= 1'b0;
    end else begin
      CFG_RDATA <= rdata_nxt;
      CFG_RVALID <= CFG_REQ.rd;
    end
  end

  // ****************************************
  // configuration forward decision
  // ****************************************
  // a cycle naming our own upstream bus is never sent downstream
  always_comb begin
    fwd_action_nxt = FWD_ACTION;
    if (FWD_REQ) begin
      if (!FWD_IS_TYPE1 || FWD_BUS == up_bus_r) begin
        fwd_action_nxt = cbss_pkg::CBSS_FWD_NONE;
      end else if (FWD_BUS == card_bus_r) begin
        fwd_action_nxt = cbss_pkg::CBSS_FWD_TYPE0;
      end else if (FWD_BUS > card_bus_r && FWD_BUS <= sub_bus_r) begin
        fwd_action_nxt = cbss_pkg::CBSS_FWD_TYPE1;
      end else begin
        fwd_action_nxt = cbss_pkg::CBSS_FWD_NONE;
      end
    end
  end

  // decision is registered; the action holds until the next request
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      FWD_VALID <= 1'b0;
      FWD_ACTION <= cbss_pkg::CBSS_FWD_NONE;
    end else begin
      FWD_VALID <= FWD_REQ;
      FWD_ACTION <= fwd_action_nxt;
    end
  end

endmodule
`default_nettype wire

/* File: inc/cbss_pkg.sv */
// package for the card-side error status and bus number block
// assumes a config access port with dword addresses and byte enables
//
// Summary of operation
// - card parity error in address or data phase sets status bit 15
// - card-driven system error sets bit 14; bridge never drives that line
// - master abort on a cycle we initiated sets bit 13
// - target abort received on a cycle we initiated sets bit 12
// - target abort signaled by us as target sets bit 11
// - writing 1 clears a clearable status bit; writing 0 leaves it
// - bits 10 to 9 always read 01b, medium select timing
// - bit 8 set on parity error seen, we are master, response enabled
// - bit 7 always reads 0, no fast back-to-back
// - bit 6 always reads 0, no user-definable features
// - bit 5 always reads 0, card clock at most 33 MHz
// - bits 4 to 0 reserved, read zero
// - sticky error bits reset only by global reset; bus reset leaves them
// - upstream bus number, 8-bit read/write, resets to zero
// - card-side bus number, 8-bit read/write, resets to zero
// - config cycles compared against all three bus numbers for forwarding
// - subordinate bus number, 8-bit read/write, upper forwarding bound
package cbss_pkg;

  // ****************************************
  // register map (byte offsets)
  // ****************************************
  localparam logic [7:0] CBSS_OFS_STATUS = 8'h16;
  localparam logic [7:0] CBSS_OFS_UP_BUS = 8'h18;
  localparam logic [7:0] CBSS_OFS_CARD_BUS = 8'h19;
  localparam logic [7:0] CBSS_OFS_SUB_BUS = 8'h1A;

  // ****************************************
  // status field positions
  // ****************************************
  localparam int CBSS_B_PARITY = 15;
  localparam int CBSS_B_SERR = 14;
  localparam int CBSS_B_MABORT = 13;
  localparam int CBSS_B_TA_RCVD = 12;
  localparam int CBSS_B_TA_SIG = 11;
  localparam int CBSS_B_SPEED_LO = 9;
  localparam int CBSS_B_DPAR = 8;
  localparam logic [1:0] CBSS_SPEED_MEDIUM = 2'h1;
  localparam logic [15:0] CBSS_STATUS_RST = 16'h0200;
  localparam logic [7:0] CBSS_BUS_RST = 8'h00;

  typedef struct packed {
    logic addr_parity_err;
    logic data_parity_err;
    logic serr_seen;
    logic master_abort;
    logic target_abort_rcvd;
    logic target_abort_sig;
    logic perr_seen;
    logic is_master;
  } cbss_event_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] dw_addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cbss_cfg_req_t;

  typedef enum logic [1:0] {
    CBSS_FWD_NONE = 2'b00,
    CBSS_FWD_TYPE0 = 2'b01,
    CBSS_FWD_TYPE1 = 2'b10
  } cbss_fwd_t;

endpackage

/* File: sim/cbss_host.sv */
// host model issuing config cycles toward the block
// assumes one cycle per call, caller samples results after return
`timescale 1ns/1ns
`default_nettype none
module cbss_host (
  input wire logic SYS_CLK,
  output cbss_pkg::cbss_cfg_req_t REQ
);
  initial REQ = '0;
  task automatic cfg(input logic w, input logic [5:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge SYS_CLK);
    #1 REQ = {w, ~w, a, b, d};
    @(posedge SYS_CLK);
    // released data flips so stale values never look valid
    #1 REQ = {2'b00, a, 4'h0, ~d};
  endtask
endmodule
`default_nettype wire

/* File: sim/cbss_regs_sva.sv */
// port checker for the card-side status and bus number block
// assumes it is bound onto cbss_regs
`timescale 1ns/1ns
`default_nettype none
module cbss_regs_sva (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire cbss_pkg::cbss_cfg_req_t CFG_REQ,
  input wire logic [31:0] CFG_RDATA,
  input wire logic CFG_RVALID,
  input wire cbss_pkg::cbss_event_t CARD_EVT,
  input wire logic CARD_SERR_OE,
  input wire logic FWD_REQ,
  input wire logic FWD_IS_TYPE1,
  input wire logic FWD_VALID,
  input wire cbss_pkg::cbss_fwd_t FWD_ACTION
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_rs; CFG_REQ.rd && CFG_REQ.dw_addr == 6'h05; endsequence
  property p_rv; CFG_REQ.rd |=> CFG_RVALID; endproperty
  a_rv: assert property (p_rv) else $error("read valid missing");
  property p_oe; !CARD_SERR_OE; endproperty
  a_oe: assert property (p_oe) else $error("error line driven");
  property p_spd; s_rs |=> CFG_RDATA[26:25] == 2'h1; endproperty
  a_spd: assert property (p_spd) else $error("select timing wrong");
  property p_zero; s_rs |=> CFG_RDATA[23:16] == 8'h00; endproperty
  a_zero: assert property (p_zero) else $error("low status not zero");
  property p_par; CARD_EVT.data_parity_err ##1 s_rs |=> CFG_RDATA[31]; endproperty
  a_par: assert property (p_par) else $error("parity bit not set");
  property p_serr; CARD_EVT.serr_seen ##1 s_rs |=> CFG_RDATA[30]; endproperty
  a_serr: assert property (p_serr) else $error("system error bit not set");
  property p_ta; CARD_EVT.target_abort_sig ##1 s_rs |=> CFG_RDATA[27]; endproperty
  a_ta: assert property (p_ta) else $error("signaled abort bit not set");
  property p_fv; FWD_REQ |=> FWD_VALID; endproperty
  a_fv: assert property (p_fv) else $error("forward valid missing");
  property p_f0; FWD_REQ && !FWD_IS_TYPE1 |=> FWD_ACTION == cbss_pkg::CBSS_FWD_NONE; endproperty
  a_f0: assert property (p_f0) else $error("type 0 forwarded");
  c_t1: cover property (FWD_VALID && FWD_ACTION == cbss_pkg::CBSS_FWD_TYPE1);
  c_t0: cover property (FWD_VALID && FWD_ACTION == cbss_pkg::CBSS_FWD_TYPE0);
  c_par: cover property (CFG_RVALID && CFG_RDATA[31]);
endmodule
bind cbss_regs cbss_regs_sva u_sva (.*);
`default_nettype wire

/* File: sim/tb_cbss_regs.sv */
// self-checking bench for the card-side status block
// assumes cbss_host drives config cycles, bench drives events
`timescale 1ns/1ns
`default_nettype none
`define CHK(n,e,a) begin checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", n, e, a); end end
module tb_cbss_regs;
  logic clk = 0, rst_n = 0, brst_n = 1, en = 0, freq = 0, ft1 = 0, rv, oe, fv;
  logic [7:0] fbus = 8'h00;
  logic [31:0] rdata;
  logic [15:0] st = 16'h0200;
  cbss_pkg::cbss_cfg_req_t req;
  cbss_pkg::cbss_event_t evt = '0;
  cbss_pkg::cbss_fwd_t fa;
  int seed = 32'h67ff, error_cnt = 0, checks = 0, e;
  cbss_host h (.SYS_CLK(clk), .REQ(req));
  cbss_regs uut (.SYS_CLK(clk), .RST_N(rst_n), .BUS_RST_N(brst_n), .CFG_REQ(req),
    .CFG_RDATA(rdata), .CFG_RVALID(rv), .CARD_EVT(evt), .PARITY_RESP_EN(en),
    .CARD_SERR_OE(oe), .FWD_REQ(freq), .FWD_IS_TYPE1(ft1), .FWD_BUS(fbus),
    .FWD_VALID(fv), .FWD_ACTION(fa));
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic rd_st;
    h.cfg(1'b0, 6'h05, 4'hF, 32'h0);
    `CHK("status", {st, 16'h0000}, rdata)
    `CHK("read valid", 1'b1, rv)
  endtask
  initial forever #5 clk = ~clk;
  // far beyond the few hundred cycles the tests need
  initial begin #200000 error_cnt++; give_verdict; end
  initial begin
    repeat (8) @(posedge clk);
    #1 rst_n = 1;
    rd_st();
    h.cfg(1'b0, 6'h06, 4'hF, 32'h0);
    `CHK("bus", 32'h0, rdata)
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      #1 e = $random(seed) & $random(seed);
      evt = e[7:0];
      en = e[8];
      st |= {evt.addr_parity_err | evt.data_parity_err, evt.serr_seen, evt.master_abort,
        evt.target_abort_rcvd, evt.target_abort_sig, 2'b00, evt.perr_seen & evt.is_master & en,
        8'h00};
      if (i % 10 == 9) begin
        @(posedge clk);
        #1 evt = '0;
        rd_st();
        e = $random(seed);
        h.cfg(1'b1, 6'h05, 4'hC, e);
        st &= ~(e[31:16] & 16'hF900);
        rd_st();
      end
    end
    $display("test events done");
    h.cfg(1'b1, 6'h06, 4'hF, 32'hFF050301);
    h.cfg(1'b0, 6'h06, 4'hF, 32'h0);
    `CHK("bus", 32'h00050301, rdata)
    for (int i = 0; i < 30; i++) begin
      @(posedge clk);
      #1 e = $random(seed);
      freq = 1;
      ft1 = e[0];
      fbus = {5'h00, e[10:8]};
      @(posedge clk);
      #1 freq = 0;
      `CHK("fwd valid", 1'b1, fv)
      `CHK("fwd", (!ft1 || fbus == 1) ? 2'h0 : fbus == 3 ? 2'h1 : fbus > 3 && fbus < 6 ? 2'h2 : 2'h0, fa)
    end
    $display("test forward done");
    @(posedge clk);
    #1 evt = '1;
    en = 1;
    st |= 16'hF900;
    rd_st();
    evt = '0;
    h.cfg(1'b1, 6'h05, 4'h4, 32'hFFFFFFFF);
    rd_st();
    brst_n = 0;
    @(posedge clk);
    #1 brst_n = 1;
    rd_st();
    h.cfg(1'b0, 6'h06, 4'hF, 32'h0);
    `CHK("bus", 32'h0, rdata)
    @(posedge clk);
    #1 rst_n = 0;
    st = 16'h0200;
    @(posedge clk);
    #1 rst_n = 1;
    rd_st();
    h.cfg(1'b0, 6'h00, 4'hF, 32'h0);
    `CHK("unmapped", 32'h0, rdata)
    `CHK("serr oe", 1'b0, oe)
    $display("test resets done");
    give_verdict;
  end
endmodule
`default_nettype wire
